// ===== logic/tacd_pkg.sv
// shared constants and types of the touch adc control word decoder
package tacd_pkg;

   // control word layout, msb first on the serial data input
   localparam int unsigned WORD_BITS      = 8;
   localparam int unsigned START_POS      = 7;
   localparam int unsigned CHAN_MSB       = 6;
   localparam int unsigned CHAN_LSB       = 4;
   localparam int unsigned MODE_POS       = 3;
   localparam int unsigned REF_POS        = 2;
   localparam int unsigned PWR1_POS       = 1;
   localparam int unsigned PWR0_POS       = 0;

   // channel address codes
   localparam logic [2:0]  CHAN_XPLUS     = 3'h1;
   localparam logic [2:0]  CHAN_AUX3      = 3'h2;
   localparam logic [2:0]  CHAN_YPLUS     = 3'h5;
   localparam logic [2:0]  CHAN_AUX4      = 3'h6;

   // settings after reset; power bit one comes up 1, power bit zero 0
   localparam logic [2:0]  CHAN_RESET     = 3'h0;
   localparam logic        MODE_RESET     = 1'h0;
   localparam logic        REF_RESET      = 1'h1;
   localparam logic        PWR1_RESET     = 1'h1;
   localparam logic        PWR0_RESET     = 1'h0;

   // serial clock counts within one word cycle
   localparam logic [3:0]  WORD_LAST_CNT  = 4'h7;
   localparam logic [3:0]  ACQ_FIRST_CNT  = 4'h4;
   localparam logic [3:0]  CYCLE_LEN_12   = 4'hF;
   localparam logic [3:0]  CYCLE_LEN_8    = 4'hB;

   // analog input steering
   typedef enum logic [2:0] {
      TACD_IN_NONE,
      TACD_IN_XPLUS,
      TACD_IN_YPLUS,
      TACD_IN_AUX3,
      TACD_IN_AUX4,
      TACD_IN_IDENT
   } tacd_input_type;

   // converter reference node steering
   typedef enum logic [1:0] {
      TACD_REF_VREF_GND,
      TACD_REF_YPLUS_YMINUS,
      TACD_REF_XPLUS_XMINUS
   } tacd_ref_type;

endpackage : tacd_pkg

// ===== logic/tacd_sync2.sv
// two flip-flop level synchroniser into the system clock domain
module tacd_sync2 #(
   parameter int unsigned WIDTH = 2
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else if (clk_en) begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : tacd_sync2

// ===== logic/tacd_link_shift.sv
// serial front end on the serial conversion clock: start hunt, shift and phases
module tacd_link_shift (
   input  wire logic       serial_conversion_clock,
   input  wire logic       serial_select_n,
   input  wire logic       serial_data_in,
   output logic      [7:0] word,
   output logic            acquire_phase,
   output logic            convert_phase
);

   logic       busy_r;
   logic [3:0] cnt_r;
   logic [5:0] shift_r;

   // the word cycle length follows the resolution of the word just taken
   wire  [3:0] cycle_len  = word[tacd_pkg::MODE_POS] ? tacd_pkg::CYCLE_LEN_8 : tacd_pkg::CYCLE_LEN_12;
   wire        cycle_end  = busy_r && (cnt_r == 4'(cycle_len - 4'h1));
   wire        word_edge  = busy_r && (cnt_r == tacd_pkg::WORD_LAST_CNT);
   wire [3:0]  cnt_inc    = cnt_r + 4'h1;

   // the clock may stop between frames, so the frame signal clears the state
   always_ff @(posedge serial_conversion_clock or posedge serial_select_n) begin
      if (serial_select_n) begin
         busy_r        <= 1'b0;
         cnt_r         <= 4'h0;
         shift_r       <= 6'h00;
         acquire_phase <= 1'b0;
         convert_phase <= 1'b0;
      end else if (!busy_r) begin
         busy_r        <= serial_data_in;
         cnt_r         <= serial_data_in ? 4'h1 : 4'h0;
         acquire_phase <= 1'b0;
         convert_phase <= 1'b0;
      end else begin
         cnt_r         <= cnt_inc;
         shift_r       <= {shift_r[4:0], serial_data_in};
         acquire_phase <= (cnt_r >= tacd_pkg::ACQ_FIRST_CNT) && (cnt_r < tacd_pkg::WORD_LAST_CNT);
         convert_phase <= (cnt_r >= tacd_pkg::WORD_LAST_CNT) && !cycle_end;
         if (cycle_end) begin
            busy_r <= 1'b0;
         end
      end
   end

   // the word is only written once a start bit opened the cycle; it has no
   // reset because the system side reads it only after a completed word
   always_ff @(posedge serial_conversion_clock) begin
      if (!serial_select_n && word_edge) begin
         word <= {1'b1, shift_r, serial_data_in};
      end
   end

endmodule : tacd_link_shift

// ===== logic/tacd_control_decoder.sv
// control word decoder of a touch screen adc: settings, steering and power
//
// Function
// - first high input bit starts a word
// - msb first: start, channel, mode, reference, power
// - channel and reference bit steer mux, drivers
// - mode bit 0 twelve bits, 1 eight
// - reference bit 1 single-ended, 0 differential
// - single-ended: drivers off after acquisition
// - differential: drivers on through acquisition, conversion
// - single-ended y: x plus input, y drivers
// - differential y: reference nodes on y pins
// - power bits reset to one, zero
// - two power bits decode power-down mode
// - new word every 15 or 11 clocks
// - first eight rising edges, only after start
// - valid channel codes; others rejected
// - power codes set power-down and interrupt enable
module tacd_control_decoder #(
   parameter logic [11:0] IDENT_CODE = 12'h5A3   // arbitrary value
) (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    clk_en,
   input  wire logic                    serial_conversion_clock,
   input  wire logic                    serial_select_n,
   input  wire logic                    serial_data_in,
   output logic      [2:0]              channel_select_bits,
   output logic                         resolution_8bit,
   output logic                         reference_kind_select,
   output logic                         power_bit_one,
   output logic                         power_bit_zero,
   output tacd_pkg::tacd_input_type     input_route,
   output tacd_pkg::tacd_ref_type       reference_route,
   output logic                         x_drivers_on,
   output logic                         y_drivers_on,
   output logic                         y_minus_ground_on,
   output logic                         converter_powered,
   output logic                         touch_interrupt_enable,
   output logic                         identity_active,
   output logic      [11:0]             identity_value,
   output logic                         acquiring,
   output logic                         converting,
   output logic                         word_accepted,
   output logic                         word_invalid
);

   // decoding helpers

   // legal channel codes; differential is only legal for the position
   // channels and the identity read, so a host slip is caught here
   function automatic logic tacd_chan_valid(input logic [2:0] ch, input logic ser);
      logic ok;
      ok = 1'b0;
      unique case (ch)
         tacd_pkg::CHAN_XPLUS: ok = 1'b1;
         tacd_pkg::CHAN_YPLUS: ok = 1'b1;
         tacd_pkg::CHAN_AUX3:  ok = ser;
         tacd_pkg::CHAN_AUX4:  ok = 1'b1;
         default:              ok = 1'b0;
      endcase
      return ok;
   endfunction : tacd_chan_valid

   // analog input selected by a channel code and reference kind
   function automatic tacd_pkg::tacd_input_type tacd_input_of(input logic [2:0] ch, input logic ser);
      tacd_pkg::tacd_input_type sel;
      sel = tacd_pkg::TACD_IN_NONE;
      unique case (ch)
         tacd_pkg::CHAN_XPLUS: sel = tacd_pkg::TACD_IN_XPLUS;
         tacd_pkg::CHAN_YPLUS: sel = tacd_pkg::TACD_IN_YPLUS;
         tacd_pkg::CHAN_AUX3:  sel = tacd_pkg::TACD_IN_AUX3;
         tacd_pkg::CHAN_AUX4:  sel = ser ? tacd_pkg::TACD_IN_AUX4 : tacd_pkg::TACD_IN_IDENT;
         default:              sel = tacd_pkg::TACD_IN_NONE;
      endcase
      return sel;
   endfunction : tacd_input_of

   // reference nodes: ground to vref single-ended and for the identity read, the far panel pins otherwise
   function automatic tacd_pkg::tacd_ref_type tacd_ref_of(input logic [2:0] ch, input logic ser);
      tacd_pkg::tacd_ref_type sel;
      sel = tacd_pkg::TACD_REF_VREF_GND;
      if (!ser && ch == tacd_pkg::CHAN_XPLUS) begin
         sel = tacd_pkg::TACD_REF_YPLUS_YMINUS;
      end else if (!ser && ch == tacd_pkg::CHAN_YPLUS) begin
         sel = tacd_pkg::TACD_REF_XPLUS_XMINUS;
      end
      return sel;
   endfunction : tacd_ref_of

   // link side and crossing

   logic [7:0] link_word;
   logic       link_acq;
   logic       link_conv;
   logic [1:0] phase_s;
   logic       conv_d_r;
   logic       ever_loaded_r;

   tacd_link_shift u_link (
      .serial_conversion_clock (serial_conversion_clock),
      .serial_select_n         (serial_select_n),
      .serial_data_in          (serial_data_in),
      .word                    (link_word),
      .acquire_phase           (link_acq),
      .convert_phase           (link_conv)
   );

   // both phase levels come from link flip-flops, so a plain pair suffices
   tacd_sync2 #(
      .WIDTH (2)
   ) u_phase_sync (
      .clk    (clk),
      .rst_n  (rst_n),
      .clk_en (clk_en),
      .d      ({link_conv, link_acq}),
      .q      (phase_s)
   );

   wire        acq_s      = phase_s[0];
   wire        conv_s     = phase_s[1];

   // the word is held still through the whole convert phase, and the phase
   // level reaches this side two clocks late, so sampling it here is safe
   wire        conv_rise  = clk_en && conv_s && !conv_d_r;
   wire [2:0]  cap_chan   = link_word[tacd_pkg::CHAN_MSB:tacd_pkg::CHAN_LSB];
   wire        cap_mode   = link_word[tacd_pkg::MODE_POS];
   wire        cap_ref    = link_word[tacd_pkg::REF_POS];
   wire        cap_pwr1   = link_word[tacd_pkg::PWR1_POS];
   wire        cap_pwr0   = link_word[tacd_pkg::PWR0_POS];
   wire        cap_valid  = tacd_chan_valid(cap_chan, cap_ref);
   wire        accept     = conv_rise && cap_valid;
   wire        reject     = conv_rise && !cap_valid;

   // held settings

   // settings change only on a complete, legal word
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         channel_select_bits    <= tacd_pkg::CHAN_RESET;
         resolution_8bit        <= tacd_pkg::MODE_RESET;
         reference_kind_select  <= tacd_pkg::REF_RESET;
         power_bit_one          <= tacd_pkg::PWR1_RESET;
         power_bit_zero         <= tacd_pkg::PWR0_RESET;
         touch_interrupt_enable <= !tacd_pkg::PWR0_RESET;
         input_route            <= tacd_pkg::TACD_IN_NONE;
         reference_route        <= tacd_pkg::TACD_REF_VREF_GND;
         identity_active        <= 1'b0;
         ever_loaded_r          <= 1'b0;
      end else if (accept) begin
         channel_select_bits    <= cap_chan;
         resolution_8bit        <= cap_mode;
         reference_kind_select  <= cap_ref;
         power_bit_one          <= cap_pwr1;
         power_bit_zero         <= cap_pwr0;
         touch_interrupt_enable <= !cap_pwr0;
         input_route            <= tacd_input_of(cap_chan, cap_ref);
         reference_route        <= tacd_ref_of(cap_chan, cap_ref);
         identity_active        <= (tacd_input_of(cap_chan, cap_ref) == tacd_pkg::TACD_IN_IDENT);
         ever_loaded_r          <= 1'b1;
      end
   end

   // drivers, power and status

   // differential keeps the panel fed through conversion too, and a no
   // power-down differential setting keeps it fed between words as well
   wire        diff_hold   = !reference_kind_select && power_bit_one && power_bit_zero;
   wire        drv_window  = acq_s || (!reference_kind_select && (conv_s || diff_hold));
   wire        x_drv_nxt   = drv_window && (channel_select_bits == tacd_pkg::CHAN_YPLUS);
   wire        y_drv_nxt   = drv_window && (channel_select_bits == tacd_pkg::CHAN_XPLUS);
   wire        active_nxt  = acq_s || conv_s;
   wire        pwr_nxt     = power_bit_one || active_nxt;
   wire        yminus_nxt  = !power_bit_one && !power_bit_zero && !active_nxt;

   // levels are registered so the switch controls never glitch
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         x_drivers_on      <= 1'b0;
         y_drivers_on      <= 1'b0;
         converter_powered <= 1'b0;
         y_minus_ground_on <= 1'b0;
         acquiring         <= 1'b0;
         converting        <= 1'b0;
         conv_d_r          <= 1'b0;
         word_accepted     <= 1'b0;
         word_invalid      <= 1'b0;
         identity_value    <= 12'h000;
      end else if (clk_en) begin
         x_drivers_on      <= x_drv_nxt;
         y_drivers_on      <= y_drv_nxt;
         converter_powered <= pwr_nxt;
         y_minus_ground_on <= yminus_nxt;
         acquiring         <= acq_s;
         converting        <= conv_s;
         conv_d_r          <= conv_s;
         word_accepted     <= accept;
         word_invalid      <= reject;
         identity_value    <= identity_active ? IDENT_CODE : 12'h000;
      end
   end

   // checks

   // until a legal word has landed the power-up settings stand
   property p_power_default;
      @(posedge clk) disable iff (!rst_n)
         !ever_loaded_r |-> (power_bit_one && !power_bit_zero);
   endproperty
   a_power_default: assert property (p_power_default)
      else $error("power bits left their reset value without a word");

   // settings hold unless a word was accepted the cycle before
   property p_settings_hold;
      @(posedge clk) disable iff (!rst_n)
         !accept |=> ($stable(channel_select_bits) && $stable(resolution_8bit)
                      && $stable(reference_kind_select) && $stable(power_bit_one));
   endproperty
   a_settings_hold: assert property (p_settings_hold)
      else $error("settings changed without an accepted word");

   // an accepted word lands in the channel and power fields
   property p_channel_load;
      @(posedge clk) disable iff (!rst_n)
         accept |=> (channel_select_bits == $past(cap_chan))
                    && (power_bit_one == $past(cap_pwr1)) && (power_bit_zero == $past(cap_pwr0));
   endproperty
   a_channel_load: assert property (p_channel_load)
      else $error("accepted word not loaded into channel or power bits");

   // the mode bit picks the resolution of the next conversion
   property p_resolution;
      @(posedge clk) disable iff (!rst_n)
         accept |=> (resolution_8bit == $past(cap_mode)) ##1 $stable(resolution_8bit) || accept;
   endproperty
   a_resolution: assert property (p_resolution)
      else $error("resolution does not follow the mode bit");

   // the reference bit picks the reference kind
   property p_reference_kind;
      @(posedge clk) disable iff (!rst_n)
         accept |=> (reference_kind_select == $past(cap_ref));
   endproperty
   a_reference_kind: assert property (p_reference_kind)
      else $error("reference kind does not follow the reference bit");

   // an illegal code is flagged one cycle later and changes nothing
   property p_reject;
      @(posedge clk) disable iff (!rst_n)
         reject |=> word_invalid && !word_accepted && $stable(channel_select_bits);
   endproperty
   a_reject: assert property (p_reject)
      else $error("illegal channel code not rejected");

   // single-ended conversion leaves the panel unpowered
   property p_single_off;
      @(posedge clk) disable iff (!rst_n)
         (clk_en && conv_s && !acq_s && reference_kind_select && !accept) [*2]
            |-> (!x_drivers_on && !y_drivers_on);
   endproperty
   a_single_off: assert property (p_single_off)
      else $error("drivers on during a single-ended conversion");

   // differential keeps the y drivers on while converting an x plus word
   property p_diff_on;
      @(posedge clk) disable iff (!rst_n)
         (clk_en && conv_s && !reference_kind_select && !accept
          && channel_select_bits == tacd_pkg::CHAN_XPLUS) [*2] |-> y_drivers_on;
   endproperty
   a_diff_on: assert property (p_diff_on)
      else $error("drivers dropped during a differential conversion");

   // single-ended y coordinate: x plus routed and y drivers on in acquisition
   property p_single_y;
      @(posedge clk) disable iff (!rst_n)
         (clk_en && acq_s && reference_kind_select && !accept
          && channel_select_bits == tacd_pkg::CHAN_XPLUS) [*2]
            |-> (y_drivers_on && !x_drivers_on && input_route == tacd_pkg::TACD_IN_XPLUS);
   endproperty
   a_single_y: assert property (p_single_y)
      else $error("single-ended y measurement steered wrongly");

   // differential y coordinate references the y panel pins
   property p_diff_y_ref;
      @(posedge clk) disable iff (!rst_n)
         (!reference_kind_select && channel_select_bits == tacd_pkg::CHAN_XPLUS)
            |-> (reference_route == tacd_pkg::TACD_REF_YPLUS_YMINUS);
   endproperty
   a_diff_y_ref: assert property (p_diff_y_ref)
      else $error("differential y reference not on the y pins");

   // power code decodes interrupt enable and power-down behaviour
   property p_power_decode;
      @(posedge clk) disable iff (!rst_n)
         (clk_en && !acq_s && !conv_s && !accept) ##1 (clk_en && !accept)
            |-> (touch_interrupt_enable == !power_bit_zero)
                && (converter_powered == power_bit_one)
                && (y_minus_ground_on == (!power_bit_one && !power_bit_zero));
   endproperty
   a_power_decode: assert property (p_power_decode)
      else $error("power bits decoded wrongly between words");

   // a word is accepted only on the rise of the convert phase
   property p_load_moment;
      @(posedge clk) disable iff (!rst_n)
         word_accepted |-> ($past(conv_s) && !$past(conv_d_r));
   endproperty
   a_load_moment: assert property (p_load_moment)
      else $error("word accepted outside the end of the control bits");

   // the identity code stands one clock after the identity read is chosen
   property p_identity_value;
      @(posedge clk) disable iff (!rst_n)
         (clk_en && identity_active) |=> (identity_value == IDENT_CODE);
   endproperty
   a_identity_value: assert property (p_identity_value)
      else $error("identity code not presented for the identity read");

   // the converter is powered whenever a word is acquired or converted
   property p_powered_busy;
      @(posedge clk) disable iff (!rst_n)
         (clk_en && (acq_s || conv_s)) |=> converter_powered;
   endproperty
   a_powered_busy: assert property (p_powered_busy)
      else $error("converter unpowered during an active word");

   // the y minus switch belongs to power-down only, never to an active word
   property p_yminus_busy;
      @(posedge clk) disable iff (!rst_n)
         (clk_en && (acq_s || conv_s)) |=> !y_minus_ground_on;
   endproperty
   a_yminus_busy: assert property (p_yminus_busy)
      else $error("y minus switch on during an active word");

   // a legal code always steers a real input, so an accepted word never maps to none
   property p_accept_route;
      @(posedge clk) disable iff (!rst_n)
         word_accepted |-> (input_route != tacd_pkg::TACD_IN_NONE);
   endproperty
   a_accept_route: assert property (p_accept_route)
      else $error("accepted word left the input unrouted");

endmodule : tacd_control_decoder

// ===== verif/tacd_host_model.sv
// host model: drives the serial control word link of the decoder
module tacd_host_model (
   output logic sclk,
   output logic sel_n,
   output logic din
);
   timeunit 1ns;
   timeprecision 1ps;

   // clock stands still outside frames; select is raised once just after start
   // so the link's asynchronous clear sees a clean edge, not a race at time zero
   initial begin
      sclk = 1'b0;
      sel_n = 1'b0;
      din = 1'b0;
      #1 sel_n = 1'b1;
   end

   // leading zeros, word msb first, then filler clocks; data changes off the rising edge
   task automatic run(input logic [7:0] w, input int zeros, input int edges, input bit keep);
      sel_n = 1'b0;
      for (int i = 0; i < zeros + edges; i++) begin
         din = (i >= zeros && i < zeros + 8) ? w[7 - (i - zeros)] : 1'b0;
         #24 sclk = 1'b1;
         #24 sclk = 1'b0;
      end
      // released line shows the inverse so a stale level is never mistaken for data
      if (!keep) begin
         #24 sel_n = 1'b1;
         din = ~din;
      end
   endtask : run
endmodule : tacd_host_model

// ===== verif/tb.sv
// self-checking testbench of the touch adc control word decoder
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] IDENT = 12'h3C6; // arbitrary value
   logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
   wire  sclk, sel_n, din;
   logic [2:0] chan;
   logic res8, refk, pw_one, pw_zero, xdrv, ydrv, ymg, tie, ida, acc, inv, pwr, acq, cnv;
   logic acq_q = 1'b0, cnv_q = 1'b0;
   logic [11:0] idv;
   tacd_pkg::tacd_input_type in_r;
   tacd_pkg::tacd_ref_type ref_r;
   int n_errors = 0, num_checks = 0, n_acc = 0, n_inv = 0, cyc = 0, n_aqr = 0, n_cvr = 0;

   tacd_host_model host (.sclk(sclk), .sel_n(sel_n), .din(din));
   tacd_control_decoder #(.IDENT_CODE(IDENT)) uut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
      .serial_conversion_clock(sclk), .serial_select_n(sel_n), .serial_data_in(din),
      .channel_select_bits(chan), .resolution_8bit(res8), .reference_kind_select(refk),
      .power_bit_one(pw_one), .power_bit_zero(pw_zero), .input_route(in_r), .reference_route(ref_r),
      .x_drivers_on(xdrv), .y_drivers_on(ydrv), .y_minus_ground_on(ymg), .converter_powered(pwr),
      .touch_interrupt_enable(tie), .identity_active(ida), .identity_value(idv),
      .acquiring(acq), .converting(cnv), .word_accepted(acc), .word_invalid(inv));

   // system clock and hang limit; pulses are counted since they stand one cycle only
   initial forever #20 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (acc === 1'b1) n_acc++;
      if (inv === 1'b1) n_inv++;
      if (acq === 1'b1 && acq_q === 1'b0) n_aqr++;
      if (cnv === 1'b1 && cnv_q === 1'b0) n_cvr++;
      acq_q <= acq;
      cnv_q <= cnv;
      if (cyc == 20000) begin
         n_errors++;
         finish_test();
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // one word, then enough clocks for the synchronised settings to land
   task automatic send(input logic [7:0] w, input int zeros, input int edges);
      host.run(w, zeros, edges, 1'b0);
      repeat (8) @(posedge clk);
   endtask : send

   task automatic t_start;
      send(8'h97, 3, 15);
      chk("accepted", 1, n_acc);
      chk("acquire_rise", 1, n_aqr);
      chk("convert_rise", 1, n_cvr);
      chk("channel", 3'h1, chan);
      chk("mode", 0, res8);
      chk("reference", 1, refk);
      chk("in_route", tacd_pkg::TACD_IN_XPLUS, in_r);
      chk("ref_route", tacd_pkg::TACD_REF_VREF_GND, ref_r);
   endtask : t_start

   // eight-bit words at the shortest spacing inside one frame
   task automatic t_b2b;
      host.run(8'hDF, 0, 11, 1'b1);
      send(8'h9F, 0, 11);
      chk("accepted", 3, n_acc);
      chk("mode", 1, res8);
   endtask : t_b2b

   task automatic t_diff;
      send(8'h93, 0, 15);
      chk("ref_route", tacd_pkg::TACD_REF_YPLUS_YMINUS, ref_r);
      chk("y_drv", 1, ydrv);
      chk("x_drv", 0, xdrv);
      send(8'hE3, 0, 15);
      chk("ident", 1, ida);
      chk("ident_val", IDENT, idv);
   endtask : t_diff

   // illegal codes and an aborted word leave the settings alone
   task automatic t_refuse;
      send(8'hF4, 2, 15);
      send(8'hA3, 0, 15);
      send(8'hD4, 0, 5);
      chk("invalid", 2, n_inv);
      chk("accepted", 5, n_acc);
      chk("channel", 3'h6, chan);
      chk("convert_rise", 7, n_cvr);
   endtask : t_refuse

   // a low clock enable freezes the decoder, so a word sent meanwhile is lost
   task automatic t_freeze;
      @(posedge clk);
      #2 clk_en = 1'b0;
      send(8'h9F, 0, 11);
      #2 clk_en = 1'b1;
      repeat (8) @(posedge clk);
      chk("accepted", 5, n_acc);
      chk("channel", 3'h6, chan);
      chk("convert_rise", 7, n_cvr);
   endtask : t_freeze

   task automatic t_power;
      for (int p = 0; p < 4; p++) begin
         send(8'hD4 | 8'(p), 0, 15);
         chk("power_one", p[1], pw_one);
         chk("power_zero", p[0], pw_zero);
         chk("irq_en", !p[0], tie);
         chk("y_minus", p == 0, ymg);
         chk("powered", p[1], pwr);
      end
   endtask : t_power

   // a reset in mid-run brings back the power-up settings
   task automatic t_reset;
      @(posedge clk);
      #2 rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #2 rst_n = 1'b1;
      @(posedge clk);
      #2 chk("power_one", 1, pw_one);
      chk("power_zero", 0, pw_zero);
      chk("channel", 3'h0, chan);
   endtask : t_reset

   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test

   // reset, reset values, then the scenarios
   initial begin
      repeat (10) @(posedge clk);
      #2 rst_n = 1'b1;
      @(posedge clk);
      #2 chk("power_one", 1, pw_one);
      chk("power_zero", 0, pw_zero);
      chk("irq_en", 1, tie);
      t_start();
      t_b2b();
      t_diff();
      t_refuse();
      t_freeze();
      t_power();
      t_reset();
      finish_test();
   end
endmodule : tb
